// ### src/ssm_alu.sv
// Function
// - Shift right arithmetic: bits move down, bit 7 kept, bit 0 to carry.
// - Shift flags: C shifted bit, Z, S, V cleared, D and H kept.
// - Shift opcodes D0 register, D1 indirect; 2 bytes, 4 cycles.
// - Halt 7F, 1 byte, 4 cycles: clocks stop, stop mode, flags kept.
// - Stop mode retains CPU, peripheral and port register contents.
// - Stop mode ends only on reset or external interrupt.
// - Subtract stores dst minus src via two's complement add.
// - Subtract flags: C borrow, Z, S, V on signed overflow.
// - Subtract sets D to 1; H set on low-nibble borrow.
// - Subtract opcodes 22..26 with given lengths and cycle counts.
// - Mask test computes NOT dst AND src, writes no operand.
// - Mask test flags: Z, S from bit 7, V cleared, C D H kept.
// - Mask test opcodes 62..66 with given lengths and cycles.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module ssm_alu
   import ssm_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 instValid,
   input  ssm_pkg::ssm_inst_t        inst,
   output logic                      instReady,
   input  wire logic                 extIrq,
   output logic                      wbValid,
   output ssm_pkg::ssm_wb_t          wb,
   output ssm_pkg::ssm_flags_t       flags,
   output logic                      stopMode,
   output logic                      cpuClkEn,
   output logic                      sysClkEn
);
   import ssm_pkg::*;

   ssm_state_t stateR;
   ssm_dec_t   dec;
   ssm_aluop_t opR;
   ssm_flags_t flagsR;
   ssm_flags_t coreFlags;
   ssm_wb_t    wbR;
   logic [7:0]  dstR;
   logic [7:0]  srcR;
   logic [7:0]  coreRes;
   logic        coreWr;
   logic [2:0]  cntR;
   logic        haltR;
   logic [1:0]  lenR;
   logic        wbValidR;
   logic        wakeEnR;
   logic        illegalR;
   logic [7:0]  lastResR;
   logic [31:0] instCntR;
   logic [31:0] prdataR;
   logic        pslverrR;
   logic        accept;
   logic        finish;
   logic        wake;
   logic        apbWr;
   logic        apbSetup;
   logic        mapped;

   // Opcode decode: operation, halt, cycle count and byte length
   always_comb begin
      dec = '{known: 1'b1, op: ALU_NONE, halt: 1'b0,
              cycles: CYC_LONG, len: LEN_THREE};
      case (inst.opcode)
         OP_ASHR_R, OP_ASHR_IR: begin
            dec.op     = ALU_ASHR;
            dec.cycles = CYC_SHORT;
            dec.len    = LEN_TWO;
         end
         OP_STOP: begin
            dec.halt   = 1'b1;
            dec.cycles = CYC_SHORT;
            dec.len    = LEN_ONE;
         end
         OP_SUB_WW: begin
            dec.op     = ALU_SUB;
            dec.cycles = CYC_SHORT;
            dec.len    = LEN_TWO;
         end
         OP_SUB_WI: begin
            dec.op     = ALU_SUB;
            dec.len    = LEN_TWO;
         end
         OP_SUB_RR, OP_SUB_RI, OP_SUB_IM: begin
            dec.op     = ALU_SUB;
         end
         OP_TIM_WW: begin
            dec.op     = ALU_TIM;
            dec.cycles = CYC_SHORT;
            dec.len    = LEN_TWO;
         end
         OP_TIM_WI: begin
            dec.op     = ALU_TIM;
            dec.len    = LEN_TWO;
         end
         OP_TIM_RR, OP_TIM_RI, OP_TIM_IM: begin
            dec.op     = ALU_TIM;
         end
         default: begin
            dec.known  = 1'b0;
         end
      endcase
   end

   // Handshake terms
   assign instReady = (stateR == ST_IDLE);
   assign accept    = instValid && instReady && dec.known;
   assign finish    = (stateR == ST_EXEC) && (cntR == CNT_DONE);
   assign wake      = extIrq && wakeEnR;
   assign apbWr     = psel && penable && pwrite;
   assign apbSetup  = psel && !penable;

   // Sequencer; stop mode leaves only on interrupt or sync reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stateR <= ST_IDLE;
      end else begin
         case (stateR)
            ST_IDLE: begin
               if (accept) begin
                  stateR <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (finish) begin
                  stateR <= haltR ? ST_STOP : ST_IDLE;
               end
            end
            ST_STOP: begin
               if (wake) begin
                  stateR <= ST_IDLE;
               end
            end
            default: begin
               stateR <= ST_IDLE;
            end
         endcase
      end
   end

   // Operand latch and cycle counter; latched values hold through stop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opR   <= ALU_NONE;
         dstR  <= 8'h00;
         srcR  <= 8'h00;
         cntR  <= 3'h0;
         haltR <= 1'b0;
         lenR  <= 2'h0;
      end else if (accept) begin
         opR   <= dec.op;
         dstR  <= inst.dst;
         srcR  <= inst.src;
         cntR  <= dec.cycles - 3'h1;
         haltR <= dec.halt;
         lenR  <= dec.len;
      end else if (stateR == ST_EXEC && !finish) begin
         cntR  <= cntR - 3'h1;
      end
   end

   ssm_alu_core u_core (
      .op       (opR),
      .dst      (dstR),
      .src      (srcR),
      .flagsIn  (flagsR),
      .res      (coreRes),
      .wrDst    (coreWr),
      .flagsOut (coreFlags)
   );

   // Flag register; non-halt completion beats a same-cycle software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flagsR <= FLAGS_RST;
      end else if (finish && !haltR) begin
         flagsR <= coreFlags;
      end else if (apbWr && paddr == REG_FLAGS) begin
         flagsR <= pwdata[5:0];
      end
   end

   // Write-back to register file, same edge as flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wbR      <= '0;
         wbValidR <= 1'b0;
         lastResR <= 8'h00;
      end else begin
         wbValidR <= finish;
         if (finish) begin
            wbR.wrDst <= coreWr && !haltR;
            wbR.data  <= coreRes;
            wbR.len   <= lenR;
            lastResR  <= coreRes;
         end
      end
   end

   // Control and status state; illegal flag set wins over clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wakeEnR  <= CTRL_WAKE_RST;
         illegalR <= 1'b0;
      end else begin
         if (apbWr && paddr == REG_CTRL) begin
            wakeEnR <= pwdata[CTRL_WAKE_BIT];
         end
         if (instValid && instReady && !dec.known) begin
            illegalR <= 1'b1;
         end else if (apbWr && paddr == REG_STATUS &&
                      pwdata[STAT_ILL_BIT]) begin
            illegalR <= 1'b0;
         end
      end
   end

   // Completed-instruction counter, wraps
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instCntR <= 32'h0000_0000;
      end else if (finish) begin
         instCntR <= instCntR + 32'h0000_0001;
      end
   end

   // Address decode for mapped words
   always_comb begin
      case (paddr)
         REG_CTRL, REG_STATUS, REG_FLAGS, REG_RESULT, REG_COUNT: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Read data captured in setup so the access phase needs no wait
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdataR  <= 32'h0000_0000;
         pslverrR <= 1'b0;
      end else if (apbSetup) begin
         pslverrR <= !mapped;
         prdataR  <= 32'h0000_0000;
         case (paddr)
            REG_CTRL: begin
               prdataR[CTRL_WAKE_BIT] <= wakeEnR;
            end
            REG_STATUS: begin
               prdataR[STAT_STOP_BIT] <= (stateR == ST_STOP);
               prdataR[STAT_BUSY_BIT] <= (stateR == ST_EXEC);
               prdataR[STAT_ILL_BIT]  <= illegalR;
            end
            REG_FLAGS: begin
               prdataR[5:0] <= flagsR;
            end
            REG_RESULT: begin
               prdataR[7:0] <= lastResR;
            end
            REG_COUNT: begin
               prdataR <= instCntR;
            end
            default: begin
               prdataR <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Outputs; clock enables drop for the whole stop period
   assign prdata   = prdataR;
   assign pslverr  = pslverrR && psel && penable;
   assign pready   = 1'b1;
   assign wb       = wbR;
   assign wbValid  = wbValidR;
   assign flags    = flagsR;
   assign stopMode = (stateR == ST_STOP);
   assign cpuClkEn = (stateR != ST_STOP);
   assign sysClkEn = (stateR != ST_STOP);

endmodule // ssm_alu

// ### src/ssm_alu_core.sv
`timescale 1ns/1ns
module ssm_alu_core
   import ssm_pkg::*;
(
   input  ssm_pkg::ssm_aluop_t op,
   input  wire logic [7:0]     dst,
   input  wire logic [7:0]     src,
   input  ssm_pkg::ssm_flags_t flagsIn,
   output logic [7:0]          res,
   output logic                wrDst,
   output ssm_pkg::ssm_flags_t flagsOut
);

   import ssm_pkg::*;

   logic [8:0] sum;
   logic [4:0] lowSum;

   // Subtract as dst plus two's complement of src
   assign sum    = {1'b0, dst} + {1'b0, ~src} + 9'h001;
   assign lowSum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;

   // Result, write enable and flag effects per operation
   always_comb begin
      res      = dst;
      wrDst    = 1'b0;
      flagsOut = flagsIn;
      case (op)
         ALU_ASHR: begin
            res        = {dst[7], dst[7:1]};
            wrDst      = 1'b1;
            flagsOut.c = dst[0];
            flagsOut.z = ({dst[7], dst[7:1]} == 8'h00);
            flagsOut.s = dst[7];
            flagsOut.v = 1'b0;
         end
         ALU_SUB: begin
            res        = sum[7:0];
            wrDst      = 1'b1;
            flagsOut.c = ~sum[8];
            flagsOut.z = (sum[7:0] == 8'h00);
            flagsOut.s = sum[7];
            flagsOut.v = (dst[7] != src[7]) && (sum[7] == src[7]);
            flagsOut.d = 1'b1;
            flagsOut.h = ~lowSum[4];
         end
         ALU_TIM: begin
            // Flags only, operands untouched
            res        = ~dst & src;
            flagsOut.z = ((~dst & src) == 8'h00);
            flagsOut.s = ~dst[7] & src[7];
            flagsOut.v = 1'b0;
         end
         default: begin
            res = dst;
         end
      endcase
   end

endmodule // ssm_alu_core

// ### src/ssm_pkg.sv
package ssm_pkg;

   // Opcodes handled by this datapath
   localparam logic [7:0] OP_ASHR_R  = 8'hD0;
   localparam logic [7:0] OP_ASHR_IR = 8'hD1;
   localparam logic [7:0] OP_STOP    = 8'h7F;
   localparam logic [7:0] OP_SUB_WW  = 8'h22;
   localparam logic [7:0] OP_SUB_WI  = 8'h23;
   localparam logic [7:0] OP_SUB_RR  = 8'h24;
   localparam logic [7:0] OP_SUB_RI  = 8'h25;
   localparam logic [7:0] OP_SUB_IM  = 8'h26;
   localparam logic [7:0] OP_TIM_WW  = 8'h62;
   localparam logic [7:0] OP_TIM_WI  = 8'h63;
   localparam logic [7:0] OP_TIM_RR  = 8'h64;
   localparam logic [7:0] OP_TIM_RI  = 8'h65;
   localparam logic [7:0] OP_TIM_IM  = 8'h66;

   // Cycle counts and byte lengths
   localparam logic [2:0] CYC_SHORT  = 3'h4;
   localparam logic [2:0] CYC_LONG   = 3'h6;
   localparam logic [1:0] LEN_ONE    = 2'h1;
   localparam logic [1:0] LEN_TWO    = 2'h2;
   localparam logic [1:0] LEN_THREE  = 2'h3;

   // APB register byte offsets
   localparam int         ADDR_W     = 8;
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_FLAGS  = 8'h08;
   localparam logic [7:0] REG_RESULT = 8'h0C;
   localparam logic [7:0] REG_COUNT  = 8'h10;

   // Field positions and reset values
   localparam int         CTRL_WAKE_BIT = 0;
   localparam int         STAT_STOP_BIT = 0;
   localparam int         STAT_BUSY_BIT = 1;
   localparam int         STAT_ILL_BIT  = 2;
   localparam logic       CTRL_WAKE_RST = 1'b1;
   localparam logic [5:0] FLAGS_RST     = 6'h00;
   localparam logic [2:0] CNT_DONE      = 3'h1;

   typedef enum logic [1:0] {
      ALU_ASHR = 2'h0,
      ALU_SUB  = 2'h1,
      ALU_TIM  = 2'h2,
      ALU_NONE = 2'h3
   } ssm_aluop_t;

   // Gray path: idle -> exec -> stop
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_STOP = 2'b11
   } ssm_state_t;

   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
      logic d;
      logic h;
   } ssm_flags_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] dst;
      logic [7:0] src;
   } ssm_inst_t;

   typedef struct packed {
      logic       wrDst;
      logic [7:0] data;
      logic [1:0] len;
   } ssm_wb_t;

   typedef struct packed {
      logic       known;
      ssm_aluop_t op;
      logic       halt;
      logic [2:0] cycles;
      logic [1:0] len;
   } ssm_dec_t;

endpackage

// ### tb/ssm_alu_props.sv
`timescale 1ns/1ns
module ssm_alu_props
   import ssm_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         instValid,
   input  ssm_pkg::ssm_inst_t  inst,
   input  wire logic         instReady,
   input  wire logic         extIrq,
   input  wire logic         wbValid,
   input  ssm_pkg::ssm_wb_t    wb,
   input  ssm_pkg::ssm_flags_t flags,
   input  wire logic         stopMode,
   input  wire logic         cpuClkEn,
   input  wire logic         sysClkEn
);
   ssm_inst_t cur_r;
   logic      take, isShort, isLong;
   assign take = instValid && instReady;
   assign isShort = inst.opcode inside {8'hD0, 8'hD1, 8'h7F, 8'h22, 8'h62};
   assign isLong = inst.opcode inside {[8'h23:8'h26], [8'h63:8'h66]};
   // Operands of the instruction in flight, kept for result checks
   always_ff @(posedge clk) begin
      if (sys_rst) cur_r <= '0;
      else if (take) cur_r <= inst;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Completion pulse is sampled on the fourth or sixth edge after taking
   sequence s_shortDone;
      ##1 (!wbValid && !instReady) [*3] ##1 wbValid;
   endsequence
   sequence s_longDone;
      ##1 (!wbValid && !instReady) [*5] ##1 wbValid;
   endsequence
   a_short_timing: assert property (
      take && isShort |-> s_shortDone)
      else $error("four cycle instruction finished at wrong time");
   a_long_timing: assert property (
      take && isLong |-> s_longDone)
      else $error("six cycle instruction finished at wrong time");
   a_wb_pulse: assert property (wbValid |=> !wbValid)
      else $error("completion pulse longer than one cycle");
   a_clocks_gated: assert property (
      cpuClkEn == !stopMode && sysClkEn == !stopMode)
      else $error("clock enables disagree with stop state");
   a_stop_holds: assert property (stopMode && !extIrq |=> stopMode)
      else $error("stop left without reset or interrupt");
   a_stop_retains: assert property (
      $past(stopMode) && stopMode |-> $stable(flags) && !instReady)
      else $error("state changed while stopped");
   a_shift_result: assert property (
      wbValid && cur_r.opcode[7:1] == 7'h68 |->
      wb.data == {cur_r.dst[7], cur_r.dst[7:1]} &&
      flags.c == cur_r.dst[0] && !flags.v)
      else $error("shift result or carry wrong");
   a_sub_result: assert property (
      wbValid && cur_r.opcode inside {[8'h22:8'h26]} |->
      wb.data == cur_r.dst - cur_r.src && flags.d &&
      flags.c == (cur_r.src > cur_r.dst))
      else $error("subtract result or flags wrong");
   a_mask_flags: assert property (
      wbValid && cur_r.opcode inside {[8'h62:8'h66]} |->
      !wb.wrDst && flags.z == ((~cur_r.dst & cur_r.src) == 8'h00) &&
      !flags.v && flags.c == $past(flags.c))
      else $error("mask test flags wrong");
   a_halt_stops: assert property (
      wbValid && cur_r.opcode == 8'h7F |->
      flags == $past(flags) && !wb.wrDst ##1 stopMode)
      else $error("halt did not stop or touched flags");
endmodule // ssm_alu_props

// ### tb/ssm_alu_tb.sv
`timescale 1ns/1ns
module ssm_alu_tb;
   import ssm_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, extIrq = 1'b0, pready, pslverr, instValid;
   logic        instReady, wbValid, stopMode, cpuClkEn, sysClkEn;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   ssm_inst_t   inst;
   ssm_wb_t     wb;
   ssm_flags_t  flags;
   int          failures = 0, compares = 0;
   always #5 clk = ~clk;
   ssm_alu u_ssm_alu (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instValid(instValid), .inst(inst), .instReady(instReady),
      .extIrq(extIrq), .wbValid(wbValid), .wb(wb), .flags(flags),
      .stopMode(stopMode), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn));
   ssm_dec_model u_ssm_dec_model (.clk(clk), .instReady(instReady),
      .wbValid(wbValid), .wb(wb), .flags(flags), .inst(inst),
      .instValid(instValid));
   task automatic check(input string name, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~wd;
   endtask
   task automatic go(input logic [7:0] op, d, s, eData, input logic [5:0] eFl,
                     input logic [1:0] eLen, input logic eWr, input int eLat);
      ssm_wb_t w;
      ssm_flags_t f;
      int lat;
      u_ssm_dec_model.run(op, d, s, w, f, lat);
      check("latency", lat, eLat);
      check("length", w.len, eLen);
      check("flags", f, eFl);
      check("writeback", w.wrDst, eWr);
      if (eWr) check("result", w.data, eData);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, REG_CTRL, 32'h0, r, e);
      check("wake reset", r, 32'h1);
      apb(1'b0, 8'h14, 32'h0, r, e);
      check("unmapped err", e, 1'b1);
   endtask
   task automatic t_shift;
      logic [31:0] r;
      logic e;
      apb(1'b1, REG_FLAGS, 32'h27, r, e);
      go(8'hD0, 8'h9A, 8'h00, 8'hCD, 6'h0B, 2'h2, 1'b1, 4);
      go(8'hD1, 8'h01, 8'h00, 8'h00, 6'h33, 2'h2, 1'b1, 4);
   endtask
   task automatic t_sub;
      logic [7:0] ops[6] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h26};
      logic [7:0] ds[6] = '{8'h12, 8'h12, 8'h21, 8'h21, 8'h21, 8'h21};
      logic [7:0] ss[6] = '{8'h03, 8'h0A, 8'h03, 8'h0A, 8'h90, 8'h65};
      logic [7:0] r;
      logic [5:0] x;
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 6; i++) begin
         r = ds[i] - ss[i];
         x = {ss[i] > ds[i], r == 8'h00, r[7],
              (ds[i][7] != ss[i][7]) && (r[7] == ss[i][7]), 1'b1,
              ss[i][3:0] > ds[i][3:0]};
         go(ops[i], ds[i], ss[i], r, x, ops[i] < 8'h24 ? 2'h2 : 2'h3, 1'b1,
            ops[i] == 8'h22 ? 4 : 6);
      end
      apb(1'b0, REG_RESULT, 32'h0, q, e);
      check("result reg", q, 32'h0000_00BC);
   endtask
   task automatic t_mask;
      logic [7:0] ds[5] = '{8'hC7, 8'hC7, 8'h2B, 8'h2B, 8'h2B};
      logic [7:0] ss[5] = '{8'h02, 8'h23, 8'h02, 8'h23, 8'h80};
      logic [7:0] r;
      logic [31:0] q;
      logic e;
      apb(1'b1, REG_FLAGS, 32'h25, q, e);
      for (int i = 0; i < 5; i++) begin
         r = ~ds[i] & ss[i];
         go(8'(8'h62 + i), ds[i], ss[i], 8'h00,
            {1'b1, r == 8'h00, r[7], 3'b001},
            i < 2 ? 2'h2 : 2'h3, 1'b0, i == 0 ? 4 : 6);
      end
   endtask
   task automatic t_illegal;
      logic [31:0] r;
      logic e;
      go(8'h00, 8'h00, 8'h00, 8'h00, 6'h29, 2'h3, 1'b0, 10);
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      check("illegal", r[2], 1'b1);
      apb(1'b0, REG_COUNT, 32'h0, r, e);
      check("count", r, 32'h0000_000D);
      apb(1'b1, REG_STATUS, 32'h4, r, e);
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      check("illegal clear", r, 32'h0);
   endtask
   task automatic t_halt;
      logic [31:0] r;
      logic e;
      apb(1'b1, REG_FLAGS, 32'h15, r, e);
      go(8'h7F, 8'h00, 8'h00, 8'h00, 6'h15, 2'h1, 1'b0, 4);
      repeat (4) @(posedge clk);
      check("clock enables", {stopMode, cpuClkEn, sysClkEn}, 3'b100);
      apb(1'b0, REG_FLAGS, 32'h0, r, e);
      check("flags kept", r, 32'h15);
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      check("stop status", r, 32'h1);
      extIrq <= 1'b1;
      repeat (2) @(posedge clk);
      check("irq wake", stopMode, 1'b0);
      extIrq <= 1'b0;
      apb(1'b1, REG_CTRL, 32'h0, r, e);
      go(8'h7F, 8'h00, 8'h00, 8'h00, 6'h15, 2'h1, 1'b0, 4);
      extIrq <= 1'b1;
      repeat (3) @(posedge clk);
      check("wake masked", stopMode, 1'b1);
      extIrq <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("reset wake", {stopMode, flags}, 7'h00);
      apb(1'b0, REG_CTRL, 32'h0, r, e);
      check("wake after reset", r, 32'h1);
      go(8'hD0, 8'h02, 8'h00, 8'h01, 6'h00, 2'h2, 1'b1, 4);
   endtask
   // Watchdog: the whole run needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs;
      t_shift;
      t_sub;
      t_mask;
      t_illegal;
      t_halt;
      conclude;
   end
endmodule // ssm_alu_tb
bind ssm_alu ssm_alu_props u_ssm_alu_props (.clk(clk), .sys_rst(sys_rst),
   .instValid(instValid), .inst(inst), .instReady(instReady),
   .extIrq(extIrq), .wbValid(wbValid), .wb(wb), .flags(flags),
   .stopMode(stopMode), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn));

// ### tb/ssm_dec_model.sv
`timescale 1ns/1ns
module ssm_dec_model
   import ssm_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         instReady,
   input  wire logic         wbValid,
   input  ssm_pkg::ssm_wb_t    wb,
   input  ssm_pkg::ssm_flags_t flags,
   output ssm_pkg::ssm_inst_t  inst,
   output logic              instValid
);
   initial begin
      instValid = 1'b0;
      inst = '0;
   end
   // Issue one instruction, hold until taken, then wait for completion
   task automatic run(input logic [7:0] op, d, s, output ssm_wb_t w,
                      output ssm_flags_t f, output int lat);
      int n;
      n = 0;
      @(posedge clk);
      instValid <= 1'b1;
      inst <= {op, d, s};
      @(posedge clk);
      while (instReady !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      instValid <= 1'b0;
      inst <= ~{op, d, s}; // Released bus shows no stale operand
      lat = 0;
      while (wbValid !== 1'b1 && lat < 10) begin
         @(posedge clk);
         lat++;
      end
      w = wb;
      f = flags;
   endtask
endmodule // ssm_dec_model
